// ### logic/flash_guard.sv
// Flash program/erase protection: control registers, mode logic, error lock.
// Assumes por_n marks power-on reset; other resets arrive on aresetn only.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module flash_guard #(
  parameter int BLOCKS = 8
) (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic standby_entry,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // CPU events
  input wire flash_guard_pkg::cpu_event_t cpu_event,
  input wire logic [15:0] array_rdata,
  // Flash array controls
  output logic program_active,
  output logic erase_active,
  output logic verify_active,
  output logic [BLOCKS-1:0] block_enable,
  output logic [15:0] array_read_data,
  output logic irq_block
);
  flash_guard_pkg::state_t st, next_st;
  logic op_busy;
  logic err_event;
  logic [7:0] wr_val;
  logic w_fire;
  logic ar_fire;
  logic write_hit;
  logic wr_ok;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == flash_guard_pkg::CTRL1_ADDR) || (a == flash_guard_pkg::CTRL2_ADDR)
      || (a == flash_guard_pkg::BLOCK_ADDR) || (a == flash_guard_pkg::STATUS_ADDR);
  endfunction

  assign op_busy = (st.mode == flash_guard_pkg::MODE_PROG)
    || (st.mode == flash_guard_pkg::MODE_ERASE);
  // Any misuse while programming or erasing
  assign err_event = op_busy && (cpu_event.fetch_read || cpu_event.exception
    || cpu_event.sleep || cpu_event.bus_release);
  assign s_awready = !st.aw_done && !st.bvalid;
  assign s_wready = !st.w_done && !st.bvalid;
  assign s_arready = !st.rvalid;
  assign ar_fire = s_arvalid && s_arready;
  assign w_fire = (st.aw_done || (s_awvalid && s_awready))
    && (st.w_done || (s_wvalid && s_wready)) && !st.bvalid;

  always_comb begin
    logic [7:0] a;
    logic [31:0] d;
    logic [7:0] nsel1;
    logic prog_sel;
    logic erase_sel;
    a = st.aw_done ? st.aw_addr : s_awaddr;
    d = st.w_done ? st.w_data : s_wdata;
    wr_val = d[7:0];
    write_hit = w_fire && s_wstrb[0];
    wr_ok = known_addr(a) && a != flash_guard_pkg::STATUS_ADDR;
    nsel1 = 8'h00;
    prog_sel = 1'b0;
    erase_sel = 1'b0;
    next_st = st;
    // Write path
    if (s_awvalid && s_awready) begin
      next_st.aw_done = 1'b1;
      next_st.aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_st.w_done = 1'b1;
      next_st.w_data = s_wdata;
    end
    if (w_fire) begin
      next_st.aw_done = 1'b0;
      next_st.w_done = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_ok ? flash_guard_pkg::RESP_OKAY : flash_guard_pkg::RESP_SLVERR;
      if (write_hit && a == flash_guard_pkg::CTRL1_ADDR) begin
        next_st.ctrl1 = wr_val & flash_guard_pkg::CTRL1_WMASK;
      end
      if (write_hit && a == flash_guard_pkg::CTRL2_ADDR) begin
        next_st.ctrl2 = (wr_val & flash_guard_pkg::CTRL2_WMASK)
          | (st.ctrl2 & ~flash_guard_pkg::CTRL2_WMASK);
      end
      if (write_hit && a == flash_guard_pkg::BLOCK_ADDR) begin
        next_st.blocks = wr_val;
      end
    end
    if (st.bvalid && s_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read path
    if (ar_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = known_addr(s_araddr) ? flash_guard_pkg::RESP_OKAY
        : flash_guard_pkg::RESP_SLVERR;
      case (s_araddr)
        flash_guard_pkg::CTRL1_ADDR: next_st.rdata = {24'h000000, st.ctrl1};
        flash_guard_pkg::CTRL2_ADDR: next_st.rdata = {24'h000000, st.ctrl2};
        flash_guard_pkg::BLOCK_ADDR: next_st.rdata = {24'h000000, st.blocks};
        flash_guard_pkg::STATUS_ADDR: next_st.rdata = {27'h0000000, st.mode};
        default: next_st.rdata = 32'h00000000;
      endcase
    end else if (st.rvalid && s_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Error flag: sticky, registers retained
    if (err_event) begin
      next_st.err = 1'b1;
    end
    next_st.ctrl2[flash_guard_pkg::C2_ERR] = next_st.err;
    // Mode selection from the control values being registered this cycle
    nsel1 = next_st.ctrl1;
    prog_sel = nsel1[flash_guard_pkg::C1_PROG] && nsel1[flash_guard_pkg::C1_UNLOCK]
      && next_st.ctrl2[flash_guard_pkg::C2_PSU] && !next_st.err
      && (next_st.blocks != 8'h00);
    erase_sel = nsel1[flash_guard_pkg::C1_ERASE] && nsel1[flash_guard_pkg::C1_UNLOCK]
      && next_st.ctrl2[flash_guard_pkg::C2_ESU] && !next_st.err
      && (next_st.blocks != 8'h00);
    case (st.mode)
      flash_guard_pkg::MODE_IDLE,
      flash_guard_pkg::MODE_PVER,
      flash_guard_pkg::MODE_EVER,
      flash_guard_pkg::MODE_PROG,
      flash_guard_pkg::MODE_ERASE: begin
        if (err_event) begin
          next_st.mode = flash_guard_pkg::MODE_IDLE;
        end else if (prog_sel) begin
          next_st.mode = flash_guard_pkg::MODE_PROG;
        end else if (erase_sel) begin
          next_st.mode = flash_guard_pkg::MODE_ERASE;
        end else if (nsel1[flash_guard_pkg::C1_PVER] && nsel1[flash_guard_pkg::C1_UNLOCK]) begin
          next_st.mode = flash_guard_pkg::MODE_PVER;
        end else if (nsel1[flash_guard_pkg::C1_EVER] && nsel1[flash_guard_pkg::C1_UNLOCK]) begin
          next_st.mode = flash_guard_pkg::MODE_EVER;
        end else begin
          next_st.mode = flash_guard_pkg::MODE_IDLE;
        end
      end
      default: next_st.mode = flash_guard_pkg::MODE_IDLE;
    endcase
    // Standby clears controls but keeps the error flag
    if (standby_entry) begin
      next_st.ctrl1 = flash_guard_pkg::CTRL1_RESET;
      next_st.ctrl2 = flash_guard_pkg::CTRL2_RESET;
      next_st.ctrl2[flash_guard_pkg::C2_ERR] = next_st.err;
      next_st.blocks = flash_guard_pkg::BLOCK_RESET;
      next_st.mode = flash_guard_pkg::MODE_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!por_n) begin
      st <= '0;
      st.mode <= flash_guard_pkg::MODE_IDLE;
      st.err <= 1'b0;
    end else if (!aresetn) begin
      // Non-power-on reset: everything but the error flag
      st <= '0;
      st.mode <= flash_guard_pkg::MODE_IDLE;
      st.err <= st.err;
      st.ctrl2[flash_guard_pkg::C2_ERR] <= st.err;
    end else begin
      st <= next_st;
    end
  end

  assign s_bvalid = st.bvalid;
  assign s_bresp = st.bresp;
  assign s_rvalid = st.rvalid;
  assign s_rdata = st.rdata;
  assign s_rresp = st.rresp;
  assign program_active = (st.mode == flash_guard_pkg::MODE_PROG);
  assign erase_active = (st.mode == flash_guard_pkg::MODE_ERASE);
  assign verify_active = (st.mode == flash_guard_pkg::MODE_PVER)
    || (st.mode == flash_guard_pkg::MODE_EVER);
  // Blocks open only while unlocked
  assign block_enable = st.ctrl1[flash_guard_pkg::C1_UNLOCK]
    ? st.blocks[BLOCKS-1:0] : '0;
  // Stored data hidden while program or erase is selected
  assign array_read_data = (st.ctrl1[flash_guard_pkg::C1_PROG] || st.ctrl1[flash_guard_pkg::C1_ERASE])
    ? 16'hFFFF : array_rdata;
  assign irq_block = op_busy || (st.err && (st.ctrl1[flash_guard_pkg::C1_PROG]
    || st.ctrl1[flash_guard_pkg::C1_ERASE]));

  // Checks
  err_sets_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    err_event |=> st.err && !program_active && !erase_active)
    else $error("error event did not set flag and abort");
  err_sticky_a: assert property (@(posedge aclk) disable iff (!por_n)
    st.err && por_n |=> st.err)
    else $error("error flag cleared without power-on reset");
  no_prog_err_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    $past(st.err) |-> !$rose(program_active) && !$rose(erase_active))
    else $error("program or erase entered in error state");
  prog_needs_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    program_active |-> st.ctrl1[flash_guard_pkg::C1_UNLOCK]
      && st.ctrl2[flash_guard_pkg::C2_PSU] && st.blocks != 8'h00)
    else $error("program mode without unlock, setup or block");
  lock_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    !st.ctrl1[flash_guard_pkg::C1_UNLOCK] |-> block_enable == '0 && !erase_active)
    else $error("locked flash left a block open");
  standby_clr_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    standby_entry |=> st.ctrl1 == 8'h00 && st.blocks == 8'h00 && st.mode == flash_guard_pkg::MODE_IDLE)
    else $error("standby did not clear controls");
  irq_err_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    st.err && st.ctrl1[flash_guard_pkg::C1_PROG] |-> irq_block)
    else $error("interrupts open in error state");
  read_hide_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    st.ctrl1[flash_guard_pkg::C1_ERASE] |-> array_read_data == 16'hFFFF)
    else $error("array data visible during erase");
  prog_cov: cover property (@(posedge aclk) disable iff (!aresetn) $rose(program_active));
  erase_cov: cover property (@(posedge aclk) disable iff (!aresetn) $rose(erase_active));
  err_cov: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st.err));
  err_ver_cov: cover property (@(posedge aclk) disable iff (!aresetn) st.err && verify_active);
endmodule
`default_nettype wire

// ### logic/flash_guard_pkg.sv
// Constants and types for the flash program/erase protection block.
// Assumes an AXI4-Lite master on aclk and a CPU core that reports its events.
// Function
// - Modes entered only via control bits
// - Software protection blocks program and erase
// - Unlock bit clear protects every block
// - Per-block select; zero protects all
// - Hardware protection aborts, clears control registers
// - Reset or standby clears control registers
// - Malfunction sets error flag, enters protection
// - Error keeps registers, aborts active mode
// - Error blocks program or erase re-entry
// - Error still allows verify modes
// - Flash read during operation raises error
// - Non-reset exception during operation raises error
// - Sleep during operation raises error
// - Bus release during operation raises error
// - Only power-on reset leaves error state
// - Error state masks interrupts while selected
// - Array read while selected returns junk
// - Program mode needs setup bit first
package flash_guard_pkg;
  localparam logic [7:0] CTRL1_ADDR = 8'h00;
  localparam logic [7:0] CTRL2_ADDR = 8'h04;
  localparam logic [7:0] BLOCK_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  // flash_control_one fields
  localparam int C1_PROG = 0;
  localparam int C1_ERASE = 1;
  localparam int C1_PVER = 2;
  localparam int C1_EVER = 3;
  localparam int C1_UNLOCK = 6;
  // flash_control_two fields
  localparam int C2_PSU = 0;
  localparam int C2_ESU = 1;
  localparam int C2_ERR = 7;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] BLOCK_RESET = 8'h00;
  localparam logic [7:0] CTRL1_WMASK = 8'h4F;
  localparam logic [7:0] CTRL2_WMASK = 8'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    MODE_IDLE = 5'h01,
    MODE_PROG = 5'h02,
    MODE_ERASE = 5'h04,
    MODE_PVER = 5'h08,
    MODE_EVER = 5'h10
  } mode_t;

  typedef struct packed {
    logic fetch_read;
    logic exception;
    logic sleep;
    logic bus_release;
  } cpu_event_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] blocks;
    logic err;
    mode_t mode;
    logic aw_done;
    logic w_done;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage

// ### test/cpu_model.sv
// Partner model: CPU-side fault events and the flash array read path.
// Assumes the bench commands every fault through inject.
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  // Clock
  input wire logic aclk,
  // Faults asked for by the bench
  input wire logic [3:0] inject,
  // Towards the guard
  output var flash_guard_pkg::cpu_event_t cpu_event,
  output logic [15:0] array_rdata
);
  logic [15:0] word = 16'hA5C3;
  // Code runs from RAM: no fetch, trap or interrupt unless commanded
  assign cpu_event = inject;
  // Word changes every cycle so a stale value cannot pass
  always @(posedge aclk) begin
    word <= {word[14:0], word[15] ^ word[13]};
  end
  assign array_rdata = word;
endmodule
`default_nettype wire

// ### test/flash_program_erase_protection_bench.sv
// Self-checking bench for the flash program/erase guard.
// Assumes flash_guard as AXI4-Lite slave and cpu_model as partner.
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_protection_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_n = 1'b0;
  logic stby = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, blk_en;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [31:0] seed = 32'h870B1F7F;
  logic [3:0] wstrb = 4'hF, inject = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, prog_act, erase_act, ver_act, irq_block;
  logic [1:0] bresp, rresp;
  logic [15:0] arr_in, arr_out;
  flash_guard_pkg::cpu_event_t cpu_event;
  int err_count = 0, n_checks = 0, cycles = 0;
  logic [31:0] tbl [8] = '{32'h41_01_FF_02, 32'h42_02_FF_04, 32'h44_00_FF_08,
    32'h48_00_FF_10, 32'h01_01_FF_01, 32'h41_00_FF_01, 32'h43_03_FF_02, 32'h41_01_00_01};
  always #12.5 aclk = ~aclk;
  cpu_model u_cpu (.aclk(aclk), .inject(inject), .cpu_event(cpu_event), .array_rdata(arr_in));
  flash_guard #(.BLOCKS(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .standby_entry(stby), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .cpu_event(cpu_event), .array_rdata(arr_in), .program_active(prog_act),
    .erase_active(erase_act), .verify_active(ver_act), .block_enable(blk_en),
    .array_read_data(arr_out), .irq_block(irq_block));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // One-hot status expected from ctrl1, ctrl2 and blocks, no error
  function automatic logic [7:0] mode_of(input logic [7:0] c1, c2, b);
    if (!c1[6]) return 8'h01;
    if (c1[0] && c2[0] && b != 8'h00) return 8'h02;
    if (c1[1] && c2[1] && b != 8'h00) return 8'h04;
    if (c1[2]) return 8'h08;
    if (c1[3]) return 8'h10;
    return 8'h01;
  endfunction
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Handshakes judged on settled values before the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    aw_hit = 1'b0;
    w_hit = 1'b0;
    b_hit = 1'b0;
    resp = 2'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(resp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar_hit, r_hit;
    logic [31:0] data;
    logic [1:0] resp;
    ar_hit = 1'b0;
    r_hit = 1'b0;
    data = 32'h00000000;
    resp = 2'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      data = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk($sformatf("read %h", a), {24'h0, e}, data);
    chk("rresp", 32'(er), 32'(resp));
  endtask
  task automatic outs(input logic [7:0] st, input logic ib, input logic sel);
    @(negedge aclk);
    chk("mode pins", 32'({ib, st == 8'h02, st == 8'h04, st > 8'h04}),
      32'({irq_block, prog_act, erase_act, ver_act}));
    chk("array data", 32'(sel ? 16'hFFFF : arr_in), 32'(arr_out));
  endtask
  task automatic pulse(input int which);
    @(posedge aclk);
    if (which == 0) aresetn <= 1'b0;
    else if (which == 1) stby <= 1'b1;
    else por_n <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    stby <= 1'b0;
    por_n <= 1'b1;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] t;
    logic [7:0] st, c1, c2;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), (i == 3) ? 8'h01 : 8'h00, 2'h0);
    rd(8'h10, 8'h00, 2'h2);
    wr(flash_guard_pkg::STATUS_ADDR, 8'h02, 2'h2);
    wr(8'h14, 8'h01, 2'h2);
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      t = (i < 8) ? tbl[i] : {1'b0, seed[10], 2'b00, seed[14:11], 6'h00, seed[9:0], 8'h00};
      st = (i < 8) ? t[7:0] : mode_of(t[31:24], t[23:16], t[15:8]);
      wr(flash_guard_pkg::BLOCK_ADDR, t[15:8], 2'h0);
      wr(flash_guard_pkg::CTRL2_ADDR, t[23:16], 2'h0);
      wr(flash_guard_pkg::CTRL1_ADDR, t[31:24], 2'h0);
      rd(flash_guard_pkg::STATUS_ADDR, st, 2'h0);
      outs(st, st == 8'h02 || st == 8'h04, t[24] | t[25]);
      chk("block_enable", 32'(t[30] ? t[15:8] : 8'h00), 32'(blk_en));
    end
    for (int i = 0; i < 4; i++) begin
      c1 = i[0] ? 8'h42 : 8'h41;
      c2 = i[0] ? 8'h02 : 8'h01;
      wr(flash_guard_pkg::BLOCK_ADDR, 8'hFF, 2'h0);
      wr(flash_guard_pkg::CTRL2_ADDR, c2, 2'h0);
      wr(flash_guard_pkg::CTRL1_ADDR, c1, 2'h0);
      @(posedge aclk);
      inject <= 4'h8 >> i;
      @(posedge aclk);
      inject <= 4'h0;
      rd(flash_guard_pkg::CTRL2_ADDR, c2 | 8'h80, 2'h0);
      rd(flash_guard_pkg::CTRL1_ADDR, c1, 2'h0);
      outs(8'h01, 1'b1, 1'b1);
      wr(flash_guard_pkg::CTRL1_ADDR, c1, 2'h0);
      rd(flash_guard_pkg::STATUS_ADDR, 8'h01, 2'h0);
      wr(flash_guard_pkg::CTRL1_ADDR, i[0] ? 8'h48 : 8'h44, 2'h0);
      rd(flash_guard_pkg::STATUS_ADDR, i[0] ? 8'h10 : 8'h08, 2'h0);
      wr(flash_guard_pkg::CTRL2_ADDR, 8'h00, 2'h0);
      pulse(i[0] ? 1 : 0);
      rd(flash_guard_pkg::CTRL2_ADDR, 8'h80, 2'h0);
      rd(flash_guard_pkg::CTRL1_ADDR, 8'h00, 2'h0);
      pulse(2);
      rd(flash_guard_pkg::CTRL2_ADDR, 8'h00, 2'h0);
    end
    wr(flash_guard_pkg::BLOCK_ADDR, 8'h3C, 2'h0);
    wr(flash_guard_pkg::CTRL2_ADDR, 8'h01, 2'h0);
    wr(flash_guard_pkg::CTRL1_ADDR, 8'h41, 2'h0);
    outs(8'h02, 1'b1, 1'b1);
    pulse(1);
    outs(8'h01, 1'b0, 1'b0);
    rd(flash_guard_pkg::BLOCK_ADDR, 8'h00, 2'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
